// *** core/bml_pkg.sv ***
// Purpose: shared constants for the boot-mode select loader
// Assumes: 24-bit word addresses, 32-bit words
// Notes:   one place for the map addresses and width codes; irq select codes stay in the loader
package bml_pkg;
  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [23:0] ROM_LO        = 24'h000000;
  localparam logic [23:0] ROM_HI        = 24'h000fff;
  localparam logic [23:0] BOOT_ADDR_0   = 24'h001000;
  localparam logic [23:0] BOOT_ADDR_1   = 24'h400000;
  localparam logic [23:0] BOOT_ADDR_2   = 24'hfff000;
  localparam logic [23:0] SRAM_VEC_BASE = 24'h809fc1;
  localparam logic [23:0] STACK_LO      = 24'h809800;
  localparam logic [23:0] STACK_HI      = 24'h809801;
  // ----------------------------------------------------------------
  // vectors and formats
  // ----------------------------------------------------------------
  localparam int          VEC_COUNT     = 64;
  localparam logic [1:0]  WID_8         = 2'h0;
  localparam logic [1:0]  WID_16        = 2'h1;
  localparam logic [1:0]  WID_32        = 2'h2;
  localparam int          SER_BITS      = 32;
  localparam int          WORD_W        = 32;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_SEL, ST_FETCH, ST_SERIAL, ST_DONE
  } bml_state_e;
endpackage

// *** core/bml_stream_if.sv ***
// Purpose: valid/ready word stream between loader modules
// Assumes: single clock
// Notes:   data held by source until ready
`timescale 1ns/1ps
interface bml_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** core/bml_skid_buf.sv ***
// Purpose: two-entry buffer in the boot data path
// Assumes: synchronous active-high reset
// Notes:   honest full and empty, no word lost on stall
`timescale 1ns/1ps
module bml_skid_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // streams
  bml_stream_if.snk in_s,
  bml_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr,  next_wr_ptr;
  logic [AW-1:0] rd_ptr,  next_rd_ptr;
  logic [AW:0]   count,   next_count;
  logic          push, pop;

  assign in_s.ready  = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    next_wr_ptr = push ? inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? inc(rd_ptr) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  property p_never_over;
    @(posedge core_clk_i) disable iff (rst_i) count <= (AW+1)'(DEPTH);
  endproperty
  a_never_over: assert property (p_never_over) else $error("buffer count over depth");
endmodule

// *** core/bml_boot_loader.sv ***
// Purpose: boot-mode select, rom decode and boot data fetch
// Assumes: all pins synchronous to core_clk_i
// Notes:   boot data delivered as a 32-bit word stream
// Notes on behaviour
// - strap high maps rom at 0x000000-0x000fff
// - boot starts in rom, no bus until selection
// - irq0-2 fetch from fixed start, 8/16/32 wide
// - irq3 boots serially, 32-bit words, host clocked
// - fixed rom vectors point into sram 0x809fc1
// - stack words 0x809800 and 0x809801 used
// - flag pin0 undriven from reset
// - edge detection suspended after reset
`timescale 1ns/1ps
module bml_boot_loader import bml_pkg::*; (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // strap and boot selection
  input  wire logic        boot_rom_select_strap_i,
  input  wire logic [3:0]  ext_irq_n_i,
  input  wire logic [1:0]  boot_width_i,
  input  wire logic        boot_done_i,
  // cpu side
  input  wire logic        cpu_req_i,
  input  wire logic [23:0] cpu_addr_i,
  output logic             rom_sel_o,
  output logic [31:0]      rom_data_o,
  output logic             rom_boot_mode_o,
  output logic             external_program_mode_o,
  output logic [23:0]      stack_base_o,
  output logic             boot_active_o,
  // boot word stream to cpu
  output logic             boot_valid_o,
  output logic [31:0]      boot_data_o,
  input  wire logic        boot_ready_i,
  // external bus
  output logic             ext_req_o,
  output logic [23:0]      ext_addr_o,
  input  wire logic [31:0] ext_rdata_i,
  input  wire logic        ext_ack_i,
  // serial port
  input  wire logic        ser_clk_i,
  input  wire logic        ser_fs_i,
  input  wire logic        ser_dat_i,
  // flag pin and interrupt mode
  input  wire logic        flag0_drive_low_i,
  output logic             general_flag_pin0_o,
  output logic             general_flag_pin0_oe_o,
  input  wire logic        edge_trigger_select_i,
  output logic             edge_trigger_select_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bml_state_e  state,      next_state;
  logic [23:0] fetch_addr, next_fetch_addr;
  logic [31:0] asm_word,   next_asm_word;
  logic [5:0]  fill,       next_fill;
  logic        word_full,  next_word_full;
  logic        ser_clk_q,  next_ser_clk_q;
  logic        ser_on,     next_ser_on;
  logic        flag_oe,    next_flag_oe;
  logic [31:0] rom_q,      next_rom_q;
  logic        rom_hit;
  logic [5:0]  lane_bits;
  logic        boot_bus;
  bml_stream_if #(.W(WORD_W)) w_in ();
  bml_stream_if #(.W(WORD_W)) w_out ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] sel_irq(input logic [3:0] n);
    case (n)
      4'he:    sel_irq = 3'h4;
      4'hd:    sel_irq = 3'h5;
      4'hb:    sel_irq = 3'h6;
      4'h7:    sel_irq = 3'h7;
      default: sel_irq = 3'h0;
    endcase
  endfunction

  function automatic logic [5:0] width_bits(input logic [1:0] w);
    case (w)
      WID_8:   width_bits = 6'h08;
      WID_16:  width_bits = 6'h10;
      default: width_bits = 6'h20;
    endcase
  endfunction

  assign lane_bits = width_bits(boot_width_i);
  // strap low leaves the range to the external bus
  assign rom_hit   = boot_rom_select_strap_i && cpu_addr_i <= ROM_HI;
  assign boot_bus  = (state == ST_FETCH) && !word_full;

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_fetch_addr = fetch_addr;
    next_asm_word   = asm_word;
    next_fill       = fill;
    next_word_full  = word_full && !w_in.ready;
    next_ser_clk_q  = ser_clk_i;
    next_ser_on     = ser_on;
    next_flag_oe    = flag_oe || flag0_drive_low_i;
    next_rom_q      = '0;
    if (cpu_req_i && rom_hit && cpu_addr_i < 24'(VEC_COUNT)) begin
      next_rom_q = {8'h00, SRAM_VEC_BASE + cpu_addr_i};
    end
    if (word_full && w_in.ready) begin
      next_fill = '0;
    end
    case (state)
      ST_IDLE: begin
        next_state = boot_rom_select_strap_i ? ST_WAIT_SEL : ST_DONE;
      end
      ST_WAIT_SEL: begin
        // level sampling: exactly one pin held low is a request
        case (sel_irq(ext_irq_n_i))
          3'h4: begin
            next_state      = ST_FETCH;
            next_fetch_addr = BOOT_ADDR_0;
          end
          3'h5: begin
            next_state      = ST_FETCH;
            next_fetch_addr = BOOT_ADDR_1;
          end
          3'h6: begin
            next_state      = ST_FETCH;
            next_fetch_addr = BOOT_ADDR_2;
          end
          3'h7: begin
            next_state = ST_SERIAL;
          end
          default: begin
            next_state = ST_WAIT_SEL;
          end
        endcase
        if (!boot_rom_select_strap_i) begin
          next_state = ST_DONE;
        end
      end
      ST_FETCH: begin
        if (boot_bus && ext_ack_i) begin
          // little-end lanes first; narrow sources pack in order
          case (boot_width_i)
            WID_8:   next_asm_word = {ext_rdata_i[7:0], asm_word[31:8]};
            WID_16:  next_asm_word = {ext_rdata_i[15:0], asm_word[31:16]};
            default: next_asm_word = ext_rdata_i;
          endcase
          next_fetch_addr = fetch_addr + 24'h000001;
          next_fill       = fill + lane_bits;
          next_word_full  = (fill + lane_bits) >= 6'(WORD_W);
        end
        if (boot_done_i) begin
          next_state = ST_DONE;
        end
      end
      ST_SERIAL: begin
        // rising edge of the host serial clock
        if (ser_clk_i && !ser_clk_q && !word_full) begin
          if (ser_fs_i || ser_on) begin
            next_asm_word  = {asm_word[30:0], ser_dat_i};
            next_fill      = fill + 6'h01;
            next_ser_on    = (fill + 6'h01) != 6'(SER_BITS);
            next_word_full = (fill + 6'h01) == 6'(SER_BITS);
          end
        end
        if (boot_done_i) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      fetch_addr <= '0;
      asm_word   <= '0;
      fill       <= '0;
      word_full  <= 1'b0;
      ser_clk_q  <= 1'b0;
      ser_on     <= 1'b0;
      flag_oe    <= 1'b0;
      rom_q      <= '0;
    end else begin
      state      <= next_state;
      fetch_addr <= next_fetch_addr;
      asm_word   <= next_asm_word;
      fill       <= next_fill;
      word_full  <= next_word_full;
      ser_clk_q  <= next_ser_clk_q;
      ser_on     <= next_ser_on;
      flag_oe    <= next_flag_oe;
      rom_q      <= next_rom_q;
    end
  end

  // ----------------------------------------------------------------
  // word buffer and outputs
  // ----------------------------------------------------------------
  assign w_in.valid   = word_full;
  assign w_in.data    = asm_word;
  assign w_out.ready  = boot_ready_i;
  assign boot_valid_o = w_out.valid;
  assign boot_data_o  = w_out.data;

  bml_skid_buf #(.W(WORD_W), .DEPTH(2)) u_buf (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_s       (w_in),
    .out_s      (w_out)
  );

  // no external cycles while waiting on selection
  assign ext_req_o  = boot_bus || (state == ST_DONE && cpu_req_i && !rom_hit);
  assign ext_addr_o = (state == ST_FETCH) ? fetch_addr : cpu_addr_i;
  assign rom_sel_o  = cpu_req_i && rom_hit;
  assign rom_data_o = rom_q;
  assign stack_base_o            = STACK_LO;
  assign boot_active_o           = (state == ST_FETCH) || (state == ST_SERIAL);
  assign rom_boot_mode_o         = boot_rom_select_strap_i;
  assign external_program_mode_o = !boot_rom_select_strap_i;
  assign general_flag_pin0_o     = 1'b0;
  assign general_flag_pin0_oe_o  = flag_oe;
  assign edge_trigger_select_o   = edge_trigger_select_i && (state == ST_DONE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sel0;
    state == ST_WAIT_SEL && ext_irq_n_i == 4'he && boot_rom_select_strap_i;
  endsequence
  sequence s_fetch_at0;
    state == ST_FETCH && fetch_addr == BOOT_ADDR_0;
  endsequence

  // a boot fetch may overlap a rom access; only a cpu pass-through is wrong
  property p_rom_map;
    cpu_req_i && boot_rom_select_strap_i && cpu_addr_i <= ROM_HI
      |-> rom_sel_o && !(ext_req_o && state == ST_DONE);
  endproperty
  a_rom_map: assert property (p_rom_map) else $error("rom not mapped in boot mode");
  property p_quiet_bus;
    state == ST_WAIT_SEL || state == ST_IDLE |-> !ext_req_o;
  endproperty
  a_quiet_bus: assert property (p_quiet_bus) else $error("bus active before selection");
  property p_irq0_start;
    s_sel0 |=> s_fetch_at0;
  endproperty
  a_irq0_start: assert property (p_irq0_start) else $error("irq0 start address wrong");
  property p_irq1_start;
    state == ST_WAIT_SEL && ext_irq_n_i == 4'hd && boot_rom_select_strap_i
      |=> state == ST_FETCH && fetch_addr == BOOT_ADDR_1;
  endproperty
  a_irq1_start: assert property (p_irq1_start) else $error("irq1 start address wrong");
  property p_serial_sel;
    state == ST_WAIT_SEL && ext_irq_n_i == 4'h7 && boot_rom_select_strap_i |=> state == ST_SERIAL;
  endproperty
  a_serial_sel: assert property (p_serial_sel) else $error("irq3 did not select serial");
  property p_vector;
    cpu_req_i && boot_rom_select_strap_i && cpu_addr_i == 24'h000000
      |=> rom_data_o == {8'h00, SRAM_VEC_BASE};
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector wrong");
  property p_stack;
    stack_base_o == STACK_LO && STACK_HI == STACK_LO + 24'h000001;
  endproperty
  a_stack: assert property (p_stack) else $error("stack words wrong");
  property p_flag_hiz;
    !flag0_drive_low_i && !general_flag_pin0_oe_o |=> !general_flag_pin0_oe_o;
  endproperty
  a_flag_hiz: assert property (p_flag_hiz) else $error("flag pin driven unasked");
  property p_edge_off;
    state != ST_DONE |-> !edge_trigger_select_o;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("edge mode during boot");
  property p_strap_low;
    cpu_req_i && !boot_rom_select_strap_i |-> !rom_sel_o;
  endproperty
  a_strap_low: assert property (p_strap_low) else $error("rom mapped with strap low");
endmodule

// *** sim/bml_boot_partner.sv ***
// Purpose: far-side model, boot memory and serial boot host
// Assumes: all lines change just after core_clk_i rising edge
// Notes:   released data toggles so a stale word never matches
`timescale 1ns/1ps
module bml_boot_partner (
  // clock
  input  wire logic        core_clk_i,
  // boot memory bus
  input  wire logic        ext_req_i,
  input  wire logic [23:0] ext_addr_i,
  input  wire logic [3:0]  wait_i,
  output logic             ext_ack_o,
  output logic [31:0]      ext_rdata_o,
  // serial boot host
  output logic             ser_clk_o,
  output logic             ser_fs_o,
  output logic             ser_dat_o
);
  logic [3:0] cnt;

  initial begin
    ext_ack_o   = 1'b0;
    ext_rdata_o = 32'h0;
    cnt         = 4'h0;
    ser_clk_o   = 1'b0;
    ser_fs_o    = 1'b0;
    ser_dat_o   = 1'b0;
  end

  // ----------------------------------------------------------------
  // memory: answers after wait_i idle cycles, one-cycle ack
  // ----------------------------------------------------------------
  // image is the address pattern {~a, a, ~a, a}, never vectors or stack data
  always @(posedge core_clk_i) begin
    if (ext_ack_o || !ext_req_i) begin
      ext_ack_o   <= 1'b0;
      ext_rdata_o <= ~ext_rdata_o;
      cnt         <= 4'h0;
    end else if (cnt >= wait_i) begin
      ext_ack_o   <= 1'b1;
      ext_rdata_o <= {~ext_addr_i[7:0], ext_addr_i[7:0], ~ext_addr_i[7:0], ext_addr_i[7:0]};
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // serial host: clock still between frames, msb first
  // ----------------------------------------------------------------
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge core_clk_i);
      ser_clk_o <= 1'b0;
      ser_dat_o <= w[i];
      ser_fs_o  <= (i == 31);
      repeat (2) @(posedge core_clk_i);
      ser_clk_o <= 1'b1;
      @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    ser_clk_o <= 1'b0;
    ser_fs_o  <= 1'b0;
    ser_dat_o <= ~w[0];
  endtask
endmodule

// *** sim/bml_boot_loader_tb.sv ***
// Purpose: self-checking bench for the boot-mode select loader
// Assumes: inputs change by non-blocking assignment at rising edge
// Notes:   outputs sampled on the falling edge, away from races
`timescale 1ns/1ps
module bml_boot_loader_tb import bml_pkg::*;;
  logic        clk, rst, strap, boot_done, cpu_req, boot_ready, flag_low, edge_sel;
  logic [3:0]  irq, wt;
  logic [1:0]  wid;
  logic [23:0] cpu_addr, stack_base, ext_addr;
  logic [31:0] rom_data, bdata, ext_rdata;
  logic        rom_sel, rbm, epm, boot_active, bvalid, ext_req, ext_ack;
  logic        ser_clk, ser_fs, ser_dat, flag_pin, flag_oe, edge_o;
  int          n_errors, compares;

  bml_boot_loader dut (.core_clk_i(clk), .rst_i(rst), .boot_rom_select_strap_i(strap), .ext_irq_n_i(irq),
    .boot_width_i(wid), .boot_done_i(boot_done), .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr),
    .rom_sel_o(rom_sel), .rom_data_o(rom_data), .rom_boot_mode_o(rbm), .external_program_mode_o(epm),
    .stack_base_o(stack_base), .boot_active_o(boot_active), .boot_valid_o(bvalid), .boot_data_o(bdata),
    .boot_ready_i(boot_ready), .ext_req_o(ext_req), .ext_addr_o(ext_addr), .ext_rdata_i(ext_rdata),
    .ext_ack_i(ext_ack), .ser_clk_i(ser_clk), .ser_fs_i(ser_fs), .ser_dat_i(ser_dat),
    .flag0_drive_low_i(flag_low), .general_flag_pin0_o(flag_pin), .general_flag_pin0_oe_o(flag_oe),
    .edge_trigger_select_i(edge_sel), .edge_trigger_select_o(edge_o));

  bml_boot_partner partner (.core_clk_i(clk), .ext_req_i(ext_req), .ext_addr_i(ext_addr), .wait_i(wt),
    .ext_ack_o(ext_ack), .ext_rdata_o(ext_rdata), .ser_clk_o(ser_clk), .ser_fs_o(ser_fs), .ser_dat_o(ser_dat));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    rst        <= 1'b1;
    strap      <= s; // strap moves only with cpu idle
    irq        <= 4'hf;
    cpu_req    <= 1'b0;
    boot_done  <= 1'b0;
    flag_low   <= 1'b0;
    edge_sel   <= 1'b0;
    boot_ready <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic get_word(output logic [31:0] w);
    int n;
    n = 0;
    @(negedge clk);
    while (!(bvalid === 1'b1 && boot_ready === 1'b1) && n < 400) begin
      n++;
      @(negedge clk);
    end
    if (n >= 400) begin
      n_errors++;
      $display("Error at %0t: no boot word", $time);
    end
    w = bdata;
    @(posedge clk);
  endtask

  // beats land low first; low byte of each memory word is its address
  function automatic logic [31:0] exp_word(input logic [23:0] b, input logic [1:0] wd, input int k);
    logic [7:0] x;
    case (wd)
      WID_8: begin
        x = b[7:0] + 8'(4 * k);
        return {x + 8'h3, x + 8'h2, x + 8'h1, x};
      end
      WID_16: begin
        x = b[7:0] + 8'(2 * k);
        return {~(x + 8'h1), x + 8'h1, ~x, x};
      end
      default: begin
        x = b[7:0] + 8'(k);
        return {~x, x, ~x, x};
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic rom_check();
    logic [23:0] al [6] = '{24'h0, 24'h5, 24'h3f, 24'h40, 24'hfff, 24'h1000};
    do_reset(1'b1);
    edge_sel <= 1'b1;
    @(negedge clk);
    chk({rbm, epm, flag_oe, edge_o}, 4'b1000, "boot mode pins");
    chk(stack_base, STACK_LO, "stack base");
    foreach (al[j]) begin
      @(posedge clk);
      cpu_req  <= 1'b1;
      cpu_addr <= al[j];
      @(negedge clk);
      chk({rom_sel, ext_req}, {al[j] <= ROM_HI, 1'b0}, "rom decode");
      @(negedge clk);
      chk(rom_data, (al[j] < 24'(VEC_COUNT)) ? 32'(SRAM_VEC_BASE + al[j]) : 32'h0, "vector");
    end
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask

  task automatic par_boot(input int i, input logic [1:0] wd, input logic [3:0] w8);
    logic [23:0] base;
    logic [31:0] got;
    base = (i == 0) ? BOOT_ADDR_0 : (i == 1) ? BOOT_ADDR_1 : BOOT_ADDR_2;
    do_reset(1'b1);
    wid <= wd;
    wt  <= w8;
    irq <= 4'hc;
    repeat (6) @(negedge clk);
    chk({ext_req, boot_active}, 2'b00, "no bus before one pin");
    @(posedge clk);
    irq <= ~(4'h1 << i); // one pin low only
    @(posedge clk);
    irq <= 4'hf;
    @(negedge clk);
    chk({ext_req, ext_addr}, {1'b1, base}, "first fetch address");
    repeat (60) @(negedge clk);
    chk(ext_req, 1'b0, "fetch paused while buffer full");
    @(posedge clk);
    boot_ready <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      get_word(got);
      chk(got, exp_word(base, wd, k), "boot word");
    end
    boot_ready <= 1'b0;
    boot_done  <= 1'b1;
    @(posedge clk);
    boot_done <= 1'b0;
    @(negedge clk);
    chk({boot_active, ext_req}, 2'b00, "idle after boot");
  endtask

  task automatic ser_boot();
    logic [31:0] got;
    do_reset(1'b1);
    irq <= 4'h7;
    repeat (3) @(posedge clk);
    irq <= 4'hf;
    @(negedge clk);
    chk({ext_req, boot_active}, 2'b01, "serial boot, bus quiet");
    partner.send_word(32'h9c3a51e7);
    partner.send_word(32'h0123abcd);
    boot_ready <= 1'b1;
    get_word(got);
    chk(got, 32'h9c3a51e7, "serial word 0");
    get_word(got);
    chk(got, 32'h0123abcd, "serial word 1");
    boot_ready <= 1'b0;
  endtask

  task automatic done_check();
    do_reset(1'b0);
    edge_sel <= 1'b1;
    @(posedge clk);
    cpu_req  <= 1'b1;
    cpu_addr <= 24'h10;
    @(negedge clk);
    chk({rom_sel, ext_req, ext_addr}, {2'b01, 24'h10}, "low range external");
    chk({rbm, epm, edge_o, flag_oe}, 4'b0110, "external mode");
    @(posedge clk);
    cpu_req  <= 1'b0;
    flag_low <= 1'b1;
    repeat (2) @(negedge clk);
    chk({flag_oe, flag_pin}, 2'b10, "flag driven low");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {clk, strap, boot_done, cpu_req, boot_ready, flag_low, edge_sel} = '0;
    rst      = 1'b1;
    irq      = 4'hf;
    wt       = 4'h0;
    wid      = WID_32;
    cpu_addr = 24'h0;
    n_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rom_check();
    par_boot(0, WID_8, 4'h0);
    par_boot(1, WID_16, 4'h3);
    par_boot(2, WID_32, 4'h1);
    ser_boot();
    done_check();
    complete_run();
  end

  // whole run is well under 1000 cycles; this limit of 20000 cycles is ample
  initial begin
    #200000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
